// File: hw/sample_fifo_write_formatter.sv
// Result FIFO write formatting, fill level, overflow and threshold logic
//
// Overview of operation
// - Modulator 0 ambient results enter the FIFO only with its write enable set and flicker off or finished.
// - With flicker on and fewer ambient than flicker samples, ambient results enter only if final processing after flicker is set.
// - Modulator 1 ambient results use the same gating with their own write enable, reset 1.
// - A modulator's compression bit, reset 0, makes its flicker samples stored in one byte when the field N below is 7 or less.
// - A modulator's difference bit stores only the change from the previous flicker sample.
// - A four-bit field N, reset 0xF, stores sample bits 0 through N of each flicker sample.
// - The FIFO interrupt is raised while the fill level exceeds twice the threshold, reset 0x7F.
// - The fill level is a byte count from 0 to 512.
// - A sticky overflow flag is set when data bound for the FIFO is lost because it does not fit in the free bytes.
module sample_fifo_write_formatter
  import sample_fifo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire sample_fifo_pkg::sample_t sample_in,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [7:0] ambient_sample_count,
  input wire logic [7:0] flicker_sample_count,
  input wire logic flicker_step_en,
  input wire logic final_after_flicker,
  input wire logic power_on_enable,
  input wire logic fifo_clear_cmd,
  output logic store_valid,
  input wire logic store_ready,
  output logic [15:0] store_data,
  output logic [1:0] store_nbytes,
  input wire logic host_byte_read,
  output logic [9:0] fifo_fill_level,
  output logic fifo_overflow,
  output logic fifo_threshold_irq
);

  import sample_fifo_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] msb_mask(input logic [3:0] msb);
    msb_mask = 16'hffff >> (FULL_MSB - msb);
  endfunction

  // Every input is an argument so a continuous assign re-evaluates on each of them
  function automatic logic ambient_allowed(input logic [7:0] cfg, input logic step_en,
                                           input logic [7:0] amb_cnt, input logic [7:0] fd_cnt,
                                           input logic final_en);
    ambient_allowed = cfg[CFG_WR_EN_BIT] && (!step_en || (amb_cnt >= fd_cnt) || final_en);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] cfg_reg [0:1];
  logic [7:0] thr_reg;
  logic [15:0] prev_reg [0:1];
  logic [9:0] level_reg;
  logic [9:0] level_next;
  logic ovf_reg;
  logic pon_prev_reg;
  logic [7:0] rdata_reg;
  logic clear_evt;
  logic [7:0] sel_cfg;
  logic [3:0] sel_msb;
  logic [15:0] raw_value;
  logic stage_push;
  logic stage_ready;
  stage_word_t push_word;
  stage_word_t st_word;
  logic st_valid;
  logic st_ready;
  logic fits;
  logic store_fire;
  logic level_dec;
  logic [9:0] thr_full;

  // Power-on rising edge acts like a FIFO clear
  assign clear_evt = fifo_clear_cmd || (power_on_enable && !pon_prev_reg);

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_reg[0] <= CFG_RESET;
      cfg_reg[1] <= CFG_RESET;
      thr_reg <= THR_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_MOD0_CFG) begin
        cfg_reg[0] <= reg_wdata & CFG_WMASK;
      end
      if (reg_addr == ADDR_MOD1_CFG) begin
        cfg_reg[1] <= reg_wdata & CFG_WMASK;
      end
      if (reg_addr == ADDR_THR) begin
        thr_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_MOD0_CFG: rdata_reg <= cfg_reg[0];
        ADDR_MOD1_CFG: rdata_reg <= cfg_reg[1];
        ADDR_THR: rdata_reg <= thr_reg;
        ADDR_LVL_HI: rdata_reg <= level_reg[9:2];
        ADDR_LVL_LO: rdata_reg <= {ovf_reg, 5'h00, level_reg[1:0]};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  assign sel_cfg = cfg_reg[sample_in.mod_sel];
  assign sel_msb = sel_cfg[CFG_MSB_LSB +: 4];
  assign sample_ready = stage_ready;
  // Blocked ambient results are consumed and dropped, not stalled
  assign stage_push = sample_valid &&
    (sample_in.is_flicker || ambient_allowed(sel_cfg, flicker_step_en, ambient_sample_count,
                                             flicker_sample_count, final_after_flicker));

  always_comb begin
    raw_value = sample_in.value;
    push_word.value = sample_in.value;
    push_word.nbytes = TWO_BYTES;
    if (sample_in.is_flicker) begin
      if (sel_cfg[CFG_DIFF_BIT]) begin
        raw_value = sample_in.value - prev_reg[sample_in.mod_sel];
      end
      push_word.value = raw_value & msb_mask(sel_msb);
      if (sel_cfg[CFG_COMP_BIT] && (sel_msb <= BYTE_MSB)) begin
        push_word.nbytes = ONE_BYTE;
      end
    end
  end

  // Previous raw sample kept per modulator for delta mode
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev_reg[0] <= 16'h0000;
      prev_reg[1] <= 16'h0000;
    end else if (clear_evt) begin
      prev_reg[0] <= 16'h0000;
      prev_reg[1] <= 16'h0000;
    end else if (sample_valid && sample_ready && sample_in.is_flicker) begin
      prev_reg[sample_in.mod_sel] <= sample_in.value;
    end
  end

  stage_fifo #(
    .WIDTH(STAGE_WIDTH),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .flush(clear_evt),
    .in_valid(stage_push),
    .in_ready(stage_ready),
    .in_data(push_word),
    .out_valid(st_valid),
    .out_ready(st_ready),
    .out_data(st_word)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // A word that cannot fit is discarded so the stage never locks up
  assign fits = (level_reg + 10'(st_word.nbytes)) <= STORE_BYTES;
  assign store_valid = st_valid && fits;
  assign st_ready = store_ready || !fits;
  assign store_data = st_word.value;
  assign store_nbytes = st_word.nbytes;
  assign store_fire = store_valid && store_ready;
  assign level_dec = host_byte_read && (level_reg != 10'h000);

  always_comb begin
    level_next = level_reg;
    if (store_fire) begin
      level_next = level_next + 10'(st_word.nbytes);
    end
    if (level_dec) begin
      level_next = level_next - 10'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      level_reg <= 10'h000;
      pon_prev_reg <= 1'b0;
    end else begin
      level_reg <= clear_evt ? 10'h000 : level_next;
      pon_prev_reg <= power_on_enable;
    end
  end

  // Loss in the clearing cycle still shows: set beats clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= (st_valid && !fits) || (ovf_reg && !clear_evt);
    end
  end

  assign thr_full = {1'b0, thr_reg, 1'b0};
  assign fifo_threshold_irq = level_reg > thr_full;
  assign fifo_fill_level = level_reg;
  assign fifo_overflow = ovf_reg;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_ambient_late_block: assert property (
    (sample_valid && !sample_in.is_flicker && flicker_step_en && !final_after_flicker &&
     (ambient_sample_count < flicker_sample_count)) |-> !stage_push)
    else $error("ambient result written before flicker finished");

  a_mod1_write_off: assert property (
    (sample_valid && !sample_in.is_flicker && sample_in.mod_sel &&
     !cfg_reg[1][CFG_WR_EN_BIT]) |-> !stage_push)
    else $error("modulator 1 ambient written while disabled");

  a_ambient_open_gate: assert property (
    (sample_valid && !sample_in.is_flicker && !flicker_step_en &&
     sel_cfg[CFG_WR_EN_BIT]) |-> stage_push)
    else $error("enabled ambient result not written");

  a_uncompressed_bytes: assert property (
    (stage_push && sample_in.is_flicker && !sel_cfg[CFG_COMP_BIT])
      |-> push_word.nbytes == TWO_BYTES)
    else $error("uncompressed flicker sample not two bytes");

  a_delta_value: assert property (
    (stage_push && sample_in.is_flicker && sel_cfg[CFG_DIFF_BIT] && sel_msb == FULL_MSB)
      |-> push_word.value == 16'(sample_in.value - prev_reg[sample_in.mod_sel]))
    else $error("delta sample value wrong");

  a_width_mask: assert property (
    (stage_push && sample_in.is_flicker)
      |-> ((push_word.value & ~msb_mask(sel_msb)) == 16'h0000) &&
          (sel_cfg[CFG_DIFF_BIT] || push_word.value == (sample_in.value & msb_mask(sel_msb))))
    else $error("flicker sample width wrong");

  a_irq_threshold: assert property (
    fifo_threshold_irq == (fifo_fill_level > (10'(thr_reg) << 1)))
    else $error("threshold interrupt mismatch");

  a_level_bound: assert property (
    fifo_fill_level <= 10'h200)
    else $error("fill level above 512");

  a_level_grow: assert property (
    (store_fire && !host_byte_read && !clear_evt)
      |=> fifo_fill_level == $past(fifo_fill_level) + 10'($past(store_nbytes)))
    else $error("fill level did not grow by stored bytes");

  a_overflow_set: assert property (
    (st_valid && !fits) |=> fifo_overflow)
    else $error("overflow not flagged on loss");

  a_overflow_sticky: assert property (
    (fifo_overflow && !clear_evt) |=> fifo_overflow)
    else $error("overflow flag dropped without clear");

  c_ambient_write: cover property (stage_push && !sample_in.is_flicker);
  c_compressed_byte: cover property (stage_push && push_word.nbytes == ONE_BYTE);
  c_overflow_rise: cover property ($rose(fifo_overflow));
  c_irq_rise: cover property ($rose(fifo_threshold_irq));

endmodule // sample_fifo_write_formatter

// File: inc/sample_fifo_pkg.sv
// Shared constants and types of the sample FIFO write formatter
package sample_fifo_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] ADDR_MOD0_CFG = 8'hf9;
  localparam logic [7:0] ADDR_MOD1_CFG = 8'hfa;
  localparam logic [7:0] ADDR_THR = 8'hfc;
  localparam logic [7:0] ADDR_LVL_HI = 8'hfd;
  localparam logic [7:0] ADDR_LVL_LO = 8'hfe;

  localparam int CFG_WR_EN_BIT = 7;
  localparam int CFG_COMP_BIT = 5;
  localparam int CFG_DIFF_BIT = 4;
  localparam int CFG_MSB_LSB = 0;
  localparam int OVF_BIT = 7;
  localparam logic [7:0] CFG_WMASK = 8'hbf;
  localparam logic [7:0] CFG_RESET = 8'h8f;
  localparam logic [7:0] THR_RESET = 8'h7f;

  localparam logic [9:0] STORE_BYTES = 10'h200;
  localparam int STAGE_DEPTH = 8;
  localparam logic [1:0] ONE_BYTE = 2'h1;
  localparam logic [1:0] TWO_BYTES = 2'h2;
  localparam logic [3:0] FULL_MSB = 4'hf;
  localparam logic [3:0] BYTE_MSB = 4'h7;

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic is_flicker;
    logic mod_sel;
    logic [15:0] value;
  } sample_t;

  typedef struct packed {
    logic [1:0] nbytes;
    logic [15:0] value;
  } stage_word_t;

  localparam int STAGE_WIDTH = $bits(stage_word_t);

endpackage

// File: hw/stage_fifo.sv
// Small flop-based staging FIFO with valid/ready on both sides
module stage_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != DEPTH_CNT);
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule // stage_fifo

// File: tb/store_sink_model.sv
// Far-side model: result store sink and host byte reader
module store_sink_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic stall,
  input wire logic drain,
  input wire logic store_valid,
  output logic store_ready,
  input wire logic [15:0] store_data,
  input wire logic [1:0] store_nbytes,
  input wire logic [9:0] fifo_fill_level,
  output logic host_byte_read,
  output logic [15:0] last_data,
  output logic [1:0] last_nbytes,
  output int word_count
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////
  // Ready changes only after an edge, like a real store
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      store_ready <= 1'b0;
      host_byte_read <= 1'b0;
      word_count <= 0;
      last_data <= 16'h0000;
      last_nbytes <= 2'h0;
    end else begin
      store_ready <= !stall;
      // Every other cycle, so the level has landed before the next read
      host_byte_read <= drain && !host_byte_read && (fifo_fill_level != 10'h000);
      if (store_valid && store_ready) begin
        word_count <= word_count + 1;
        last_data <= store_data;
        last_nbytes <= store_nbytes;
      end
    end
  end
endmodule // store_sink_model

// File: tb/sample_fifo_write_formatter_tb.sv
// Self-checking testbench of the sample FIFO write formatter
module sample_fifo_write_formatter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sample_fifo_pkg::*;
  logic clk_sys, rstn, reg_wr, reg_rd, sample_valid, sample_ready, flicker_step_en;
  logic final_after_flicker, power_on_enable, fifo_clear_cmd, store_valid, store_ready;
  logic host_byte_read, fifo_overflow, fifo_threshold_irq, stall, drain;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ambient_sample_count, flicker_sample_count;
  logic [15:0] store_data, last_data;
  logic [1:0] store_nbytes, last_nbytes;
  logic [9:0] fifo_fill_level;
  sample_t sample_in;
  int word_count, fails, check_count;
  ////////////////////
  sample_fifo_write_formatter i_sample_fifo_write_formatter (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_in(sample_in), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .ambient_sample_count(ambient_sample_count),
    .flicker_sample_count(flicker_sample_count), .flicker_step_en(flicker_step_en),
    .final_after_flicker(final_after_flicker), .power_on_enable(power_on_enable),
    .fifo_clear_cmd(fifo_clear_cmd), .store_valid(store_valid), .store_ready(store_ready),
    .store_data(store_data), .store_nbytes(store_nbytes), .host_byte_read(host_byte_read),
    .fifo_fill_level(fifo_fill_level), .fifo_overflow(fifo_overflow),
    .fifo_threshold_irq(fifo_threshold_irq));
  store_sink_model i_store_sink_model (.clk_sys(clk_sys), .rstn(rstn), .stall(stall),
    .drain(drain), .store_valid(store_valid), .store_ready(store_ready),
    .store_data(store_data), .store_nbytes(store_nbytes), .fifo_fill_level(fifo_fill_level),
    .host_byte_read(host_byte_read), .last_data(last_data), .last_nbytes(last_nbytes),
    .word_count(word_count));
  ////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = !clk_sys;
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    check("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  // Valid held until the edge that sees ready high
  task automatic push(input logic f, input logic m, input logic [15:0] v);
    @(negedge clk_sys);
    sample_in = '{f, m, v};
    sample_valid = 1'b1;
    while (sample_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    sample_valid = 1'b0;
  endtask
  task automatic wait_words(input int target);
    for (int i = 0; i < 30 && word_count < target; i++) @(negedge clk_sys);
    repeat (2) @(negedge clk_sys);
  endtask
  // Dropped samples must leave the word count alone
  task automatic send(input logic f, input logic m, input logic [15:0] v, input logic take,
                      input logic [15:0] ed, input logic [1:0] en);
    int n;
    n = word_count;
    push(f, m, v);
    wait_words(n + 1);
    check("words", 16'(n + int'(take)), 16'(word_count));
    if (take) begin
      check("store_data", ed, last_data);
      check("store_nbytes", {14'h0, en}, {14'h0, last_nbytes});
    end
  endtask
  task automatic clear_fifo();
    @(negedge clk_sys);
    fifo_clear_cmd = 1'b1;
    @(negedge clk_sys);
    fifo_clear_cmd = 1'b0;
  endtask
  task automatic report_and_stop();
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////
  initial begin
    {reg_wr, reg_rd, sample_valid, fifo_clear_cmd, stall, drain, final_after_flicker} = '0;
    {reg_addr, reg_wdata} = '0;
    sample_in = '0;
    ambient_sample_count = 8'h02;
    flicker_sample_count = 8'h04;
    flicker_step_en = 1'b1;
    power_on_enable = 1'b1;
    rstn = 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    reg_read(ADDR_MOD0_CFG, CFG_RESET);
    reg_read(ADDR_MOD1_CFG, CFG_RESET);
    reg_read(ADDR_THR, THR_RESET);
    reg_read(8'h10, 8'h00);
    reg_write(ADDR_MOD0_CFG, 8'hff);
    reg_read(ADDR_MOD0_CFG, 8'hbf);
    reg_write(ADDR_MOD0_CFG, 8'h8f);
    send(1'b1, 1'b0, 16'h1234, 1'b1, 16'h1234, TWO_BYTES);
    reg_write(ADDR_MOD0_CFG, 8'ha3);
    send(1'b1, 1'b0, 16'h1234, 1'b1, 16'h0004, ONE_BYTE);
    reg_write(ADDR_MOD0_CFG, 8'ha8);
    send(1'b1, 1'b0, 16'h1234, 1'b1, 16'h0034, TWO_BYTES);
    reg_write(ADDR_MOD0_CFG, 8'hb7);
    send(1'b1, 1'b0, 16'h0010, 1'b1, 16'h00dc, ONE_BYTE);
    send(1'b1, 1'b0, 16'h0015, 1'b1, 16'h0005, ONE_BYTE);
    send(1'b1, 1'b1, 16'hbeef, 1'b1, 16'hbeef, TWO_BYTES);
    reg_write(ADDR_MOD0_CFG, 8'h8f);
    send(1'b0, 1'b0, 16'habcd, 1'b0, 16'h0, 2'h0);
    final_after_flicker = 1'b1;
    send(1'b0, 1'b0, 16'habcd, 1'b1, 16'habcd, TWO_BYTES);
    final_after_flicker = 1'b0;
    flicker_step_en = 1'b0;
    send(1'b0, 1'b0, 16'h1357, 1'b1, 16'h1357, TWO_BYTES);
    flicker_step_en = 1'b1;
    ambient_sample_count = 8'h04;
    send(1'b0, 1'b0, 16'h2468, 1'b1, 16'h2468, TWO_BYTES);
    reg_write(ADDR_MOD0_CFG, 8'h0f);
    send(1'b0, 1'b0, 16'h1111, 1'b0, 16'h0, 2'h0);
    reg_write(ADDR_MOD0_CFG, 8'h8f);
    reg_write(ADDR_MOD1_CFG, 8'h0f);
    send(1'b0, 1'b1, 16'h2222, 1'b0, 16'h0, 2'h0);
    reg_write(ADDR_MOD1_CFG, 8'h8f);
    send(1'b0, 1'b1, 16'h3333, 1'b1, 16'h3333, TWO_BYTES);
    clear_fifo();
    check("level", 16'h0, {6'h0, fifo_fill_level});
    reg_write(ADDR_THR, 8'h01);
    send(1'b0, 1'b0, 16'h4444, 1'b1, 16'h4444, TWO_BYTES);
    check("irq", 16'h0, {15'h0, fifo_threshold_irq});
    send(1'b0, 1'b0, 16'h5555, 1'b1, 16'h5555, TWO_BYTES);
    check("irq", 16'h1, {15'h0, fifo_threshold_irq});
    reg_read(ADDR_LVL_HI, 8'h01);
    reg_read(ADDR_LVL_LO, 8'h00);
    drain = 1'b1;
    for (int i = 0; i < 40 && fifo_fill_level != 10'h0; i++) @(negedge clk_sys);
    drain = 1'b0;
    check("irq", 16'h0, {15'h0, fifo_threshold_irq});
    check("level", 16'h0, {6'h0, fifo_fill_level});
    // Staging buffer: fill until it refuses while the store stalls
    stall = 1'b1;
    for (int i = 0; i < STAGE_DEPTH; i++) push(1'b0, 1'b0, 16'(i));
    check("sample_ready", 16'h0, {15'h0, sample_ready});
    stall = 1'b0;
    wait_words(word_count + STAGE_DEPTH);
    check("level", 16'h10, {6'h0, fifo_fill_level});
    check("store_valid", 16'h0, {15'h0, store_valid});
    clear_fifo();
    reg_write(ADDR_THR, 8'hff);
    for (int i = 0; i < 255; i++) push(1'b0, 1'b0, 16'(i));
    wait_words(word_count + 1);
    check("irq", 16'h0, {15'h0, fifo_threshold_irq});
    send(1'b0, 1'b0, 16'h6666, 1'b1, 16'h6666, TWO_BYTES);
    check("irq", 16'h1, {15'h0, fifo_threshold_irq});
    reg_read(ADDR_LVL_HI, 8'h80);
    reg_read(ADDR_LVL_LO, 8'h00);
    push(1'b0, 1'b0, 16'h7777);
    repeat (4) @(negedge clk_sys);
    reg_read(ADDR_LVL_LO, 8'h80);
    check("fifo_overflow", 16'h1, {15'h0, fifo_overflow});
    check("level", 16'h200, {6'h0, fifo_fill_level});
    clear_fifo();
    reg_read(ADDR_LVL_LO, 8'h00);
    check("fifo_overflow", 16'h0, {15'h0, fifo_overflow});
    // Power-on rising edge must clear like the clear command
    send(1'b0, 1'b0, 16'h8888, 1'b1, 16'h8888, TWO_BYTES);
    power_on_enable = 1'b0;
    @(negedge clk_sys);
    power_on_enable = 1'b1;
    @(negedge clk_sys);
    check("level", 16'h0, {6'h0, fifo_fill_level});
    report_and_stop();
  end
  // Run takes about 3000 ns; allow a wide margin
  initial begin
    #80000;
    fails++;
    report_and_stop();
  end
endmodule // sample_fifo_write_formatter_tb
